// *** inc/spc_pkg.sv ***
package spc_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned JOG_HOLD_MS = 500;
  // long press threshold, 0.5 s at the system clock
  localparam int unsigned JOG_HOLD_CYC = JOG_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned CLR_MS = 50;
  localparam int unsigned CLR_CYC = CLR_MS * (CLK_HZ / 1000);

  // command byte: bit 7 requests, bits 6:0 carry the command number
  localparam int unsigned CMD_REQ_BIT = 7;
  localparam logic [6:0] CMD_INTERACT = 7'h7A;
  localparam logic [6:0] CMD_CAPTURE = 7'h7B;
  localparam logic [6:0] CMD_JOG_POS = 7'h7C;
  localparam logic [6:0] CMD_JOG_NEG = 7'h7D;
  localparam logic [6:0] CMD_SEEK = 7'h7E;
  localparam logic [6:0] CMD_RELOAD = 7'h7F;
  localparam logic [6:0] PROF_COUNT = 7'h19;

  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_UNSUP = 8'h01;
  localparam logic [7:0] ERR_NOREF = 8'h02;

  // host word addresses; table-relative except SPECIAL_PTR_ADDR, which is absolute
  localparam logic [15:0] SPECIAL_PTR_ADDR = 16'h00F0;
  localparam logic [15:0] IB_BASE = 16'h0010;
  localparam logic [15:0] IB_TARGET_OFS = 16'h0001;
  localparam logic [15:0] IB_RPOFS_OFS = 16'h0002;
  localparam logic [15:0] PROF_BASE = 16'h0020;
  localparam logic [1:0] CFG_LAST = 2'h2;

  localparam logic [31:0] RST_JOG_DIST = 32'h0000_0010;
  localparam logic [31:0] RST_JOG_PERIOD = 32'h0000_0064;
  localparam logic [31:0] DECEL_STEPS = 32'h0000_0004;
  localparam int unsigned CACHE_DEPTH = 4;

endpackage

// *** verilog/spc_cache.sv ***
`timescale 1ns/1ns
module spc_cache (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic inv,
  input wire logic [6:0] look_id,
  output logic hit,
  input wire logic wr_en,
  input wire logic [6:0] wr_id,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data,
  output logic [spc_pkg::CACHE_DEPTH-1:0] valid_bits
);
  import spc_pkg::*;

  logic [CACHE_DEPTH-1:0] valid_reg;
  logic [6:0] tag_reg [CACHE_DEPTH];
  logic [31:0] mem_reg [CACHE_DEPTH];
  logic [CACHE_DEPTH-1:0] match;
  logic [1:0] hit_idx;
  logic [1:0] victim_reg;
  logic [31:0] rd_data_reg;

  genvar g;
  generate
    for (g = 0; g < CACHE_DEPTH; g++) begin : g_tag
      assign match[g] = valid_reg[g] && (tag_reg[g] == look_id);
    end
  endgenerate

  always_comb begin
    hit_idx = 2'h0;
    for (int i = 0; i < CACHE_DEPTH; i++) begin
      if (match[i]) begin
        hit_idx = 2'(i);
      end
    end
  end

  assign hit = |match;
  assign rd_data = rd_data_reg;
  assign valid_bits = valid_reg;

  // invalidation wins over a fill in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      valid_reg <= '0;
      victim_reg <= 2'h0;
      for (int i = 0; i < CACHE_DEPTH; i++) begin
        tag_reg[i] <= 7'h00;
      end
    end else if (inv) begin
      valid_reg <= '0;
      victim_reg <= 2'h0;
    end else if (wr_en) begin
      valid_reg[victim_reg] <= 1'b1;
      tag_reg[victim_reg] <= wr_id;
      victim_reg <= victim_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_reg[victim_reg] <= wr_data;
    end
    rd_data_reg <= mem_reg[hit_idx];
  end

endmodule

// *** verilog/spc_unit.sv ***
// How it works
// - capture writes current position minus reference into host field
// - after that write the current position becomes zero
// - jog released before 0.5 s moves exactly the jog step distance
// - jog held 0.5 s or more runs on at jog speed
// - command byte back to idle while jogging decelerates to a stop
// - positive jog steps positive, negative jog steps negative
// - seek command searches reference using the configured method
// - reference found and stopped loads position from host offset field
// - successful seek ends with one 50 ms clear pulse
// - reload reads table pointer from special memory, then configuration
// - new configuration compared; only differing items applied
// - any reconfiguration invalidates every cached profile
// - up to four profiles of execution data held locally
// - cached profile starts at once without host memory reads
// - cache miss reads profile block and computes data before moving
// - interactive move always rereads host block and stores nothing
`timescale 1ns/1ns
module spc_unit #(
  parameter int unsigned JOG_HOLD = spc_pkg::JOG_HOLD_CYC,
  parameter int unsigned CLR_LEN = spc_pkg::CLR_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] cmd_byte,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic ref_sensor,
  output logic step_pulse,
  output logic step_dir,
  output logic clear_pulse_output,
  output logic cmd_done,
  output logic [7:0] cmd_error,
  output logic [31:0] position,
  output logic ref_found
);
  import spc_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_OFS_WR, S_JOG, S_RUN, S_DECEL, S_SEEK, S_SEEK_RD,
    S_PTR_RD, S_CFG_RD, S_CFG_APPLY, S_LOOKUP, S_HIT_WAIT, S_PROF_RD,
    S_MOVE, S_DONE
  } spc_state_t;

  spc_state_t state_reg;
  logic [6:0] code_reg;
  logic [31:0] pos_reg;
  logic [31:0] ref_pos_reg;
  logic ref_found_reg;
  logic [15:0] ptr_reg;
  logic [15:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] jog_step_distance;
  logic [31:0] jog_period_reg;
  logic [31:0] decel_period_reg;
  logic seek_dir_reg;
  logic recalc_reg;
  logic [1:0] cfg_idx_reg;
  logic [31:0] move_dist_reg;
  logic [31:0] steps_reg;
  logic dir_reg;
  logic [31:0] hold_cnt_reg;
  logic [31:0] tick_cnt_reg;
  logic step_reg;
  logic [31:0] clr_cnt_reg;
  logic clr_reg;
  logic done_reg;
  logic [7:0] err_reg;
  logic held;
  logic stepping;
  logic step_fire;
  logic [31:0] cur_period;
  logic cache_hit;
  logic cache_wr;
  logic cache_inv;
  logic [31:0] cache_rdata;
  logic [CACHE_DEPTH-1:0] cache_valid;
  logic clr_start;

  assign held = (cmd_byte == {1'b1, code_reg});
  assign mem_req = (state_reg == S_OFS_WR) || (state_reg == S_SEEK_RD) ||
                   (state_reg == S_PTR_RD) || (state_reg == S_CFG_RD) ||
                   (state_reg == S_PROF_RD);
  assign mem_we = (state_reg == S_OFS_WR);
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;
  assign step_pulse = step_reg;
  assign step_dir = dir_reg;
  assign clear_pulse_output = clr_reg;
  assign cmd_done = done_reg;
  assign cmd_error = err_reg;
  assign position = pos_reg;
  assign ref_found = ref_found_reg;

  ////////////////////////////////////////////////////////////////////////////
  // profile cache
  // reload invalidates cache
  assign cache_inv = (state_reg == S_CFG_APPLY);
  assign cache_wr = (state_reg == S_PROF_RD) && mem_ack &&
                    (code_reg != CMD_INTERACT);
  assign clr_start = (state_reg == S_SEEK_RD) && mem_ack;

  spc_cache u_cache (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .inv(cache_inv),
    .look_id(code_reg),
    .hit(cache_hit),
    .wr_en(cache_wr),
    .wr_id(code_reg),
    .wr_data(mem_rdata),
    .rd_data(cache_rdata),
    .valid_bits(cache_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // step rate divider
  always_comb begin
    stepping = 1'b0;
    cur_period = jog_period_reg;
    case (state_reg)
      S_JOG: stepping = (steps_reg < jog_step_distance);
      S_RUN: stepping = 1'b1;
      S_SEEK: stepping = !ref_sensor;
      S_MOVE: stepping = (steps_reg < move_dist_reg);
      S_DECEL: begin
        stepping = (steps_reg < DECEL_STEPS);
        cur_period = decel_period_reg;
      end
      default: stepping = 1'b0;
    endcase
  end

  assign step_fire = stepping && (tick_cnt_reg >= cur_period);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= 32'h0000_0000;
      step_reg <= 1'b0;
    end else begin
      step_reg <= step_fire;
      if (!stepping || step_fire) begin
        tick_cnt_reg <= 32'h0000_0000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      code_reg <= 7'h00;
      pos_reg <= 32'h0000_0000;
      ref_pos_reg <= 32'h0000_0000;
      ref_found_reg <= 1'b0;
      ptr_reg <= 16'h0000;
      addr_reg <= 16'h0000;
      wdata_reg <= 32'h0000_0000;
      jog_step_distance <= RST_JOG_DIST;
      jog_period_reg <= RST_JOG_PERIOD;
      decel_period_reg <= {RST_JOG_PERIOD[30:0], 1'b0};
      seek_dir_reg <= 1'b0;
      recalc_reg <= 1'b0;
      cfg_idx_reg <= 2'h0;
      move_dist_reg <= 32'h0000_0000;
      steps_reg <= 32'h0000_0000;
      dir_reg <= 1'b0;
      hold_cnt_reg <= 32'h0000_0000;
      err_reg <= ERR_NONE;
    end else begin
      if (step_fire) begin
        pos_reg <= dir_reg ? pos_reg + 32'h0000_0001
                           : pos_reg - 32'h0000_0001;
        steps_reg <= steps_reg + 32'h0000_0001;
      end
      case (state_reg)
        S_IDLE: begin
          if (cmd_byte[CMD_REQ_BIT] && !done_reg) begin
            code_reg <= cmd_byte[6:0];
            steps_reg <= 32'h0000_0000;
            hold_cnt_reg <= 32'h0000_0000;
            err_reg <= ERR_NONE;
            case (cmd_byte[6:0])
              CMD_CAPTURE: begin
                if (!ref_found_reg) begin
                  err_reg <= ERR_NOREF;
                  state_reg <= S_DONE;
                end else begin
                  wdata_reg <= pos_reg - ref_pos_reg;
                  addr_reg <= ptr_reg + IB_BASE + IB_RPOFS_OFS;
                  state_reg <= S_OFS_WR;
                end
              end
              CMD_JOG_POS, CMD_JOG_NEG: begin
                dir_reg <= (cmd_byte[6:0] == CMD_JOG_POS);
                state_reg <= S_JOG;
              end
              CMD_SEEK: begin
                dir_reg <= seek_dir_reg;
                state_reg <= S_SEEK;
              end
              CMD_RELOAD: begin
                addr_reg <= SPECIAL_PTR_ADDR;
                state_reg <= S_PTR_RD;
              end
              CMD_INTERACT: begin
                addr_reg <= ptr_reg + IB_BASE + IB_TARGET_OFS;
                state_reg <= S_PROF_RD;
              end
              default: begin
                if (cmd_byte[6:0] < PROF_COUNT) begin
                  state_reg <= S_LOOKUP;
                end else begin
                  err_reg <= ERR_UNSUP;
                  state_reg <= S_DONE;
                end
              end
            endcase
          end
        end
        S_OFS_WR: begin
          if (mem_ack) begin
            pos_reg <= 32'h0000_0000;
            ref_pos_reg <= ref_pos_reg - pos_reg;
            state_reg <= S_DONE;
          end
        end
        S_JOG: begin
          if (held) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
          end
          if (held && hold_cnt_reg >= JOG_HOLD - 1) begin
            state_reg <= S_RUN;
          // short press ends after the increment
          end else if (!held && !stepping) begin
            state_reg <= S_DONE;
          end
        end
        S_RUN: begin
          if (!held) begin
            steps_reg <= 32'h0000_0000;
            state_reg <= S_DECEL;
          end
        end
        S_DECEL: begin
          if (!stepping) begin
            state_reg <= S_DONE;
          end
        end
        S_SEEK: begin
          // stepping already stops on the sensor level
          if (ref_sensor) begin
            addr_reg <= ptr_reg + IB_BASE + IB_RPOFS_OFS;
            state_reg <= S_SEEK_RD;
          end
        end
        S_SEEK_RD: begin
          if (mem_ack) begin
            pos_reg <= mem_rdata;
            ref_pos_reg <= mem_rdata;
            ref_found_reg <= 1'b1;
            state_reg <= S_DONE;
          end
        end
        S_PTR_RD: begin
          if (mem_ack) begin
            ptr_reg <= mem_rdata[15:0];
            addr_reg <= mem_rdata[15:0];
            cfg_idx_reg <= 2'h0;
            recalc_reg <= 1'b0;
            state_reg <= S_CFG_RD;
          end
        end
        S_CFG_RD: begin
          if (mem_ack) begin
            case (cfg_idx_reg)
              2'h0: begin
                if (mem_rdata != jog_step_distance) begin
                  jog_step_distance <= mem_rdata;
                end
              end
              2'h1: begin
                if (mem_rdata != jog_period_reg) begin
                  jog_period_reg <= mem_rdata;
                  recalc_reg <= 1'b1;
                end
              end
              default: begin
                if (mem_rdata[0] != seek_dir_reg) begin
                  seek_dir_reg <= mem_rdata[0];
                end
              end
            endcase
            addr_reg <= addr_reg + 16'h0001;
            cfg_idx_reg <= cfg_idx_reg + 2'h1;
            if (cfg_idx_reg == CFG_LAST) begin
              state_reg <= S_CFG_APPLY;
            end
          end
        end
        S_CFG_APPLY: begin
          // ramp only recomputed when the speed moved
          if (recalc_reg) begin
            decel_period_reg <= {jog_period_reg[30:0], 1'b0};
          end
          state_reg <= S_DONE;
        end
        S_LOOKUP: begin
          if (cache_hit) begin
            state_reg <= S_HIT_WAIT;
          end else begin
            addr_reg <= ptr_reg + PROF_BASE + {9'h000, code_reg};
            state_reg <= S_PROF_RD;
          end
        end
        S_HIT_WAIT: begin
          dir_reg <= cache_rdata[31];
          move_dist_reg <= {1'b0, cache_rdata[30:0]};
          state_reg <= S_MOVE;
        end
        S_PROF_RD: begin
          if (mem_ack) begin
            dir_reg <= mem_rdata[31];
            move_dist_reg <= {1'b0, mem_rdata[30:0]};
            state_reg <= S_MOVE;
          end
        end
        S_MOVE: begin
          if (!stepping) begin
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion and clear pulse
  // done held until byte idles
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
    end else if (state_reg == S_DONE) begin
      done_reg <= 1'b1;
    end else if (!cmd_byte[CMD_REQ_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // one clear pulse of fixed length
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clr_reg <= 1'b0;
      clr_cnt_reg <= 32'h0000_0000;
    end else if (clr_start) begin
      clr_reg <= 1'b1;
      clr_cnt_reg <= 32'h0000_0000;
    end else if (clr_reg) begin
      clr_cnt_reg <= clr_cnt_reg + 32'h0000_0001;
      if (clr_cnt_reg >= CLR_LEN - 1) begin
        clr_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  ofs_write_a: assert property (
    (state_reg == S_IDLE && cmd_byte == {1'b1, CMD_CAPTURE} && !done_reg
     && ref_found_reg) |=> mem_we && mem_wdata ==
     $past(pos_reg) - $past(ref_pos_reg)) else $error("bad offset write");
  pos_zero_a: assert property (
    (state_reg == S_OFS_WR && mem_ack) |=> pos_reg == 32'h0000_0000 ##1
    cmd_done) else $error("position not zeroed");
  jog_incr_a: assert property (
    (state_reg == S_JOG) |-> steps_reg <= jog_step_distance)
    else $error("jog overshoot");
  jog_run_a: assert property (
    (state_reg == S_JOG && held && hold_cnt_reg == JOG_HOLD - 1)
    |=> state_reg == S_RUN) else $error("long jog not running");
  jog_stop_a: assert property (
    (state_reg == S_RUN && !held) |=> state_reg == S_DECEL)
    else $error("jog release ignored");
  jog_dir_a: assert property (
    (state_reg == S_JOG && code_reg == CMD_JOG_NEG && step_pulse)
    |-> !step_dir) else $error("negative jog wrong direction");
  seek_load_a: assert property (
    (state_reg == S_SEEK_RD && mem_ack) |=> pos_reg == $past(mem_rdata)
    && clear_pulse_output) else $error("seek load wrong");
  clr_len_a: assert property (
    clear_pulse_output |-> clr_cnt_reg < CLR_LEN)
    else $error("clear pulse too long");
  cache_inv_a: assert property (
    (state_reg == S_CFG_APPLY) |=> cache_valid == '0)
    else $error("cache kept after reload");
  hit_start_a: assert property (
    (state_reg == S_LOOKUP && cache_hit) |=> !mem_req ##1
    state_reg == S_MOVE) else $error("cached profile refetched");
  inter_nostore_a: assert property (
    (state_reg == S_PROF_RD && code_reg == CMD_INTERACT) |-> !cache_wr)
    else $error("interactive data cached");
  done_flag_a: assert property (
    (state_reg == S_DONE) |=> cmd_done && state_reg == S_IDLE)
    else $error("done not reported");

endmodule

// *** verif/spc_host_mem.sv ***
`timescale 1ns/1ns
module spc_host_mem (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic [3:0] wait_reg;
  int acc_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle ack after lat idle cycles; read data toggles outside the ack
  // so a late sample never sees a stale word
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      wait_reg <= 4'h0;
      acc_cnt <= 0;
      mem_rdata <= 32'hA5A5_5A5A;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      wait_reg <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_reg >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[7:0]];
      acc_cnt <= acc_cnt + 1;
      if (mem_we) begin
        mem[mem_addr[7:0]] <= mem_wdata;
      end
    end else begin
      wait_reg <= wait_reg + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// *** verif/test_stepper_position_command_unit.sv ***
`timescale 1ns/1ns
module test_stepper_position_command_unit;
  import spc_pkg::*;
  localparam int unsigned HOLD = 50;
  localparam int unsigned CLRL = 20;
  logic clk_sys = 1'b0;
  logic rstn, mem_req, mem_we, mem_ack, ref_sensor, step_pulse, step_dir;
  logic clear_pulse_output, cmd_done, ref_found;
  logic [3:0] lat;
  logic [7:0] cmd_byte, cmd_error;
  logic [15:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata, position, exp_pos;
  int miscompares = 0;
  int samples_checked = 0;
  int ps, ns, clr_w, i, a0;

  spc_unit #(.JOG_HOLD(HOLD), .CLR_LEN(CLRL)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .cmd_byte(cmd_byte), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ref_sensor(ref_sensor),
    .step_pulse(step_pulse), .step_dir(step_dir),
    .clear_pulse_output(clear_pulse_output), .cmd_done(cmd_done),
    .cmd_error(cmd_error), .position(position), .ref_found(ref_found)
  );
  spc_host_mem host_u (
    .clk_sys(clk_sys), .rstn(rstn), .lat(lat), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata)
  );

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (step_pulse === 1'b1) begin
      if (step_dir === 1'b1) ps++;
      else ns++;
    end
    if (clear_pulse_output === 1'b1) clr_w++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task wait_done(input logic lvl);
    int n;
    n = 0;
    while (cmd_done !== lvl) begin
      @(negedge clk_sys);
      n++;
      if (n > 20000) begin
        miscompares++;
        results();
      end
    end
  endtask

  // hold > 0 releases the byte early, as a short jog press does
  task issue(input logic [6:0] code, input int hold, input logic [7:0] err);
    @(negedge clk_sys);
    cmd_byte = {1'b1, code};
    if (hold > 0) begin
      repeat (hold) @(negedge clk_sys);
      cmd_byte = 8'h00;
    end
    wait_done(1'b1);
    check({24'h0, cmd_error}, {24'h0, err});
    cmd_byte = 8'h00;
    wait_done(1'b0);
  endtask

  task run_prof(input logic [6:0] n, input int miss);
    a0 = host_u.acc_cnt;
    issue(n, 0, ERR_NONE);
    check(32'(host_u.acc_cnt - a0), 32'(miss));
    exp_pos = exp_pos + 32'h1;
    check(position, exp_pos);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    cmd_byte = 8'h00;
    ref_sensor = 1'b0;
    lat = 4'h0;
    for (i = 0; i < 256; i++) host_u.mem[i] = 32'h0;
    host_u.mem[1] = 32'h2;
    host_u.mem[0] = 32'h4;
    host_u.mem[8'h11] = {1'b0, 31'h2};
    host_u.mem[8'h12] = 32'h55;
    for (i = 0; i < 5; i++) host_u.mem[8'h20 + i] = {1'b1, 31'h1};
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    check({30'h0, cmd_done, mem_req}, 32'h0);
    check({30'h0, ref_found, clear_pulse_output}, 32'h0);
    check(position, 32'h0);
    issue(CMD_CAPTURE, 0, ERR_NOREF);
    issue(7'h50, 0, ERR_UNSUP);
    a0 = host_u.acc_cnt;
    issue(CMD_RELOAD, 0, ERR_NONE);
    check(32'(host_u.acc_cnt - a0), 32'h4);
    // short presses, both directions
    ps = 0;
    ns = 0;
    issue(CMD_JOG_POS, 10, ERR_NONE);
    check(32'(ps), 32'h4);
    check(32'(ns), 32'h0);
    issue(CMD_JOG_NEG, 10, ERR_NONE);
    check(32'(ns), 32'h4);
    check(position, 32'h0);
    // long press runs on, then stops after release
    ps = 0;
    issue(CMD_JOG_POS, HOLD + 40, ERR_NONE);
    check(32'(ps > 12), 32'h1);
    a0 = ps;
    repeat (20) @(negedge clk_sys);
    check(32'(ps), 32'(a0));
    // seek with a slow host
    lat = 4'h3;
    ps = 0;
    ns = 0;
    clr_w = 0;
    @(negedge clk_sys);
    cmd_byte = {1'b1, CMD_SEEK};
    for (i = 0; i < 5000 && (ps + ns) < 3; i++) @(negedge clk_sys);
    check(32'(i < 5000), 32'h1);
    if (i >= 5000) results();
    ref_sensor = 1'b1;
    wait_done(1'b1);
    check({24'h0, cmd_error}, {24'h0, ERR_NONE});
    cmd_byte = 8'h00;
    ref_sensor = 1'b0;
    wait_done(1'b0);
    repeat (CLRL + 10) @(negedge clk_sys);
    check(32'(clr_w), 32'(CLRL));
    check(position, 32'h55);
    check({31'h0, ref_found}, 32'h1);
    // capture only once reference known and jogged to start
    issue(CMD_JOG_POS, 10, ERR_NONE);
    issue(CMD_CAPTURE, 0, ERR_NONE);
    check(host_u.mem[8'h12], 32'h4);
    check(position, 32'h0);
    // fill five profiles into four entries, round-robin evicts profile 0
    lat = 4'h0;
    exp_pos = 32'h0;
    for (i = 0; i < 5; i++) run_prof(i[6:0], 1);
    for (i = 4; i > 0; i--) run_prof(i[6:0], 0);
    run_prof(7'h0, 1);
    issue(CMD_RELOAD, 0, ERR_NONE);
    run_prof(7'h4, 1);
    for (i = 0; i < 2; i++) begin
      a0 = host_u.acc_cnt;
      issue(CMD_INTERACT, 0, ERR_NONE);
      check(32'(host_u.acc_cnt - a0), 32'h1);
      exp_pos = exp_pos - 32'h2;
      check(position, exp_pos);
    end
    results();
  end
endmodule
